// file: verif/dmcc_clock_control_properties.sv
// Checker of the clock control block's port behaviour.
module dmcc_clock_control_properties
	import dmcc_pkg::*;
(
	// Inputs of the block
	input  wire logic       i_clock,
	input  wire logic       i_rst,
	input  wire logic       i_ctrl_write,
	input  wire logic       i_enable,
	input  wire logic       i_fast_osc_enable,
	input  wire logic       i_input_interrupt,
	input  wire logic       i_any_interrupt,
	input  wire logic       i_supply_voltage_detector_busy,
	// Outputs of the block
	input  wire logic [1:0] o_mode,
	input  wire logic       o_cpu_clock_select,
	input  wire logic       o_fast_osc_enable,
	input  wire logic       o_slow_osc_run,
	input  wire logic       o_fast_osc_run,
	input  wire logic       o_cpu_clock_run,
	input  wire logic       o_high_speed,
	input  wire logic       o_low_power,
	input  dmcc_pkg::dmcc_state_t o_state
);
	default clocking cb @(posedge i_clock); endclocking
	default disable iff (i_rst);
	reset_values_a: assert property ($past(i_rst) |-> o_mode == MODE_RESET && !o_cpu_clock_select
		&& !o_fast_osc_enable && !o_fast_osc_run && o_slow_osc_run && o_state == DMCC_RUN) else $error("reset values");
	mode_decode_a: assert property (o_high_speed == o_mode[MODE_HI_BIT]
		&& o_low_power == (o_mode == MODE_LOW_POWER)) else $error("mode decode");
	low_power_slow_a: assert property (o_low_power |-> !o_fast_osc_run) else $error("fast in low power");
	fast_off_a: assert property (i_ctrl_write && i_enable && o_state == DMCC_RUN && !i_fast_osc_enable
		|-> ##2 !o_fast_osc_enable && !o_fast_osc_run) else $error("fast not stopped");
	detector_wait_a: assert property (o_state == DMCC_SLEEP_REQ && $past(i_supply_voltage_detector_busy)
		|=> o_state == DMCC_SLEEP_REQ && o_slow_osc_run) else $error("sleep not delayed");
	sleep_off_a: assert property (o_state == DMCC_SLEEP && $past(o_state) == DMCC_SLEEP
		|-> !o_slow_osc_run && !o_fast_osc_run && !o_cpu_clock_run) else $error("sleep oscillators");
	sleep_wake_a: assert property (o_state == DMCC_SLEEP && !i_input_interrupt && !$past(i_input_interrupt)
		|=> o_state != DMCC_RUN) else $error("sleep woke");
	halt_run_a: assert property (o_state == DMCC_HALT |-> o_slow_osc_run && !o_cpu_clock_run)
		else $error("halt clocks");
	halt_wake_a: assert property (o_state == DMCC_HALT && i_any_interrupt && i_enable
		|-> ##[1:2] o_state == DMCC_RUN) else $error("halt no wake");
	standby_hold_a: assert property (o_state != DMCC_RUN |-> $stable(o_mode) && $stable(o_fast_osc_enable))
		else $error("standby changed");
	cover property (o_state == DMCC_HALT);
	cover property (o_state == DMCC_SLEEP);
	cover property (o_cpu_clock_select && o_fast_osc_run);
endmodule // dmcc_clock_control_properties
bind dmcc_clock_control dmcc_clock_control_properties u_props (.*);

// file: verif/dmcc_clock_control_tb.sv
// Self-checking bench of the clock control block.
module dmcc_clock_control_tb;
	timeunit 1ns;
	timeprecision 1ps;
	import dmcc_pkg::*;
	logic i_clock = 0, i_rst = 1, i_enable = 1, i_slow_osc = 0, i_fast_osc = 0, i_ctrl_write = 0;
	logic i_mode_select_hi = 0, i_mode_select_lo = 0, i_cpu_clock_select = 0, i_fast_osc_enable = 0;
	logic i_sleep_instruction = 0, i_halt_instruction = 0, i_input_interrupt = 0, i_any_interrupt = 0;
	logic i_supply_voltage_detector_busy = 0;
	logic [1:0] o_mode;
	logic o_cpu_clock_select, o_fast_osc_enable, o_slow_osc_run, o_fast_osc_run, o_cpu_clock_run;
	logic o_high_speed, o_low_power, o_cpu_clock, o_timer_clock;
	dmcc_state_t o_state;
	int n_mismatch = 0, cmp_count = 0;
	int n_cpu_rise = 0, n_tmr_rise = 0, c_cpu = 0, c_tmr = 0;
	realtime t_rise = 0.0, min_high = 100.0;
	dmcc_clock_control dut (.*);
	initial forever #5 i_clock = ~i_clock;
	initial forever #3 i_slow_osc = ~i_slow_osc;
	initial forever #2 i_fast_osc = ~i_fast_osc;
	always @(posedge o_cpu_clock)
	begin
		t_rise = $realtime;
		n_cpu_rise++;
	end
	always @(negedge o_cpu_clock)
		if (t_rise > 20.0 && $realtime - t_rise < min_high)
			min_high = $realtime - t_rise;
	always @(posedge o_timer_clock)
		n_tmr_rise++;
	task automatic tick(input int n);
		repeat (n) @(negedge i_clock);
	endtask
	task automatic check(input string name, input logic [1:0] exp, input logic [1:0] got);
		cmp_count++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("BAD %s expected %h seen %h", name, exp, got);
		end
	endtask
	task automatic wr(input logic [1:0] mode, input logic sel, input logic en);
		tick(1);
		{i_mode_select_hi, i_mode_select_lo, i_cpu_clock_select, i_fast_osc_enable} = {mode, sel, en};
		i_ctrl_write = 1;
		tick(1);
		i_ctrl_write = 0;
		tick(2);
	endtask
	task automatic stop_test;
		$display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
		if (n_mismatch == 0 && cmp_count > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	initial
	begin
		#100000;
		n_mismatch++;
		stop_test;
	end
	initial
	begin
		tick(2);
		i_rst = 0;
		tick(1);
		check("mode", MODE_RESET, o_mode);
		check("run", 2'h1, {o_fast_osc_run, o_slow_osc_run});
		check("sel_en", 2'h0, {o_cpu_clock_select, o_fast_osc_enable});
		for (int m = 3; m >= 0; m--)
		begin
			wr(m[1:0], 1'b0, 1'b0);
			check("mode", m[1:0], o_mode);
			check("speed", {m[1], m == 1}, {o_high_speed, o_low_power});
		end
		wr(MODE_LOW_POWER, 1'b0, 1'b0);
		check("lp_sel_en", 2'h0, {o_cpu_clock_select, o_fast_osc_enable});
		check("lp_fast", 2'h1, {o_fast_osc_run, o_low_power});
		tick(5);
		wr(MODE_NORMAL, 1'b0, 1'b1);
		check("fast_run", 2'h3, {o_fast_osc_run, o_fast_osc_enable});
		tick(20);
		wr(MODE_NORMAL, 1'b1, 1'b1);
		for (int k = 0; k < 100 && o_cpu_clock_select !== 1'b1; k++) tick(1);
		check("on_fast", 2'h3, {o_cpu_clock_select, o_slow_osc_run});
		$display("test modes and switch done");
		i_halt_instruction = 1;
		tick(1);
		i_halt_instruction = 0;
		tick(3);
		check("state", DMCC_HALT, o_state);
		check("halt_run", 2'h3, {o_fast_osc_run, o_slow_osc_run});
		check("halt_cpu_run", 2'h0, o_cpu_clock_run);
		c_cpu = n_cpu_rise;
		c_tmr = n_tmr_rise;
		tick(2);
		check("halt_clk", 2'h2, {n_tmr_rise != c_tmr, n_cpu_rise != c_cpu});
		wr(MODE_NORMAL, 1'b0, 1'b0);
		check("halt_en", 2'h1, o_fast_osc_enable);
		i_any_interrupt = 1;
		tick(1);
		i_any_interrupt = 0;
		tick(3);
		check("state", DMCC_RUN, o_state);
		check("resume", 2'h3, {o_cpu_clock_select, o_fast_osc_enable});
		wr(MODE_NORMAL, 1'b0, 1'b1);
		for (int k = 0; k < 100 && o_cpu_clock_select !== 1'b0; k++) tick(1);
		wr(MODE_NORMAL, 1'b0, 1'b0);
		check("fast_off", 2'h0, {o_cpu_clock_select, o_fast_osc_run});
		wr(MODE_NORMAL, 1'b0, 1'b1);
		$display("test halt done");
		i_supply_voltage_detector_busy = 1;
		i_sleep_instruction = 1;
		tick(1);
		i_sleep_instruction = 0;
		tick(4);
		check("state", DMCC_SLEEP_REQ, o_state);
		check("slow_wait", 2'h1, o_slow_osc_run);
		i_supply_voltage_detector_busy = 0;
		tick(4);
		check("state", DMCC_SLEEP, o_state);
		check("sleep_run", 2'h0, {o_fast_osc_run, o_slow_osc_run});
		c_cpu = n_cpu_rise;
		c_tmr = n_tmr_rise;
		tick(2);
		check("sleep_clk", 2'h0, {n_tmr_rise != c_tmr, n_cpu_rise != c_cpu});
		i_any_interrupt = 1;
		tick(1);
		i_any_interrupt = 0;
		tick(3);
		check("state", DMCC_SLEEP, o_state);
		i_input_interrupt = 1;
		tick(1);
		i_input_interrupt = 0;
		tick(4);
		check("state", DMCC_RUN, o_state);
		check("wake_en", 2'h1, o_fast_osc_enable);
		c_cpu = n_cpu_rise;
		tick(2);
		check("wake_clk", 2'h3, {o_cpu_clock_run, n_cpu_rise != c_cpu});
		i_enable = 0;
		wr(MODE_NORMAL, 1'b0, 1'b0);
		check("frozen_en", 2'h1, o_fast_osc_enable);
		i_enable = 1;
		check("min_high", 2'h1, {1'b0, min_high > 1.5});
		$display("test sleep done");
		stop_test;
	end
endmodule // dmcc_clock_control_tb

// file: verilog/dmcc_clk_switch.sv
// Glitch-free two-source clock multiplexer for the CPU clock.
module dmcc_clk_switch
(
	// Sources
	input  wire logic i_slow_clk,
	input  wire logic i_fast_clk,
	// Control
	input  wire logic i_rst,
	input  wire logic i_select_fast,
	input  wire logic i_gate,
	// Output
	output logic      o_clk,
	output logic      o_on_fast
);
	import dmcc_pkg::*;

	logic want_fast;
	logic want_slow;
	logic fast_s1;
	logic fast_s2;
	logic slow_s1;
	logic slow_s2;
	logic fast_g1;
	logic fast_g2;
	logic slow_g1;
	logic slow_g2;

	// Each side is enabled only after the other side has dropped.
	assign want_fast = i_select_fast & ~slow_s2;
	assign want_slow = ~i_select_fast & ~fast_s2;

	always_ff @(negedge i_fast_clk)
	begin
		if (i_rst)
		begin
			fast_s1 <= 1'b0;
			fast_s2 <= 1'b0;
			fast_g1 <= 1'b0;
			fast_g2 <= 1'b0;
		end
		else
		begin
			fast_s1 <= want_fast;
			fast_s2 <= fast_s1;
			fast_g1 <= i_gate;
			fast_g2 <= fast_g1;
		end
	end

	always_ff @(negedge i_slow_clk)
	begin
		if (i_rst)
		begin
			slow_s1 <= 1'b0;
			slow_s2 <= 1'b0;
			slow_g1 <= 1'b0;
			slow_g2 <= 1'b0;
		end
		else
		begin
			slow_s1 <= want_slow;
			slow_s2 <= slow_s1;
			slow_g1 <= i_gate;
			slow_g2 <= slow_g1;
		end
	end

	// Enables and gates change only while their own clock is low, so no pulse is cut.
	assign o_clk     = (i_fast_clk & fast_s2 & fast_g2) | (i_slow_clk & slow_s2 & slow_g2);
	assign o_on_fast = fast_s2;

endmodule // dmcc_clk_switch

// file: verilog/dmcc_clock_control.sv
// Top of the dual oscillator mode and clock control block.

module dmcc_clock_control
(
	// Clock, reset, enable
	input  wire logic       i_clock,
	input  wire logic       i_rst,
	input  wire logic       i_enable,
	// Oscillator sources
	input  wire logic       i_slow_osc,
	input  wire logic       i_fast_osc,
	// Control bits
	input  wire logic       i_ctrl_write,
	input  wire logic       i_mode_select_hi,
	input  wire logic       i_mode_select_lo,
	input  wire logic       i_cpu_clock_select,
	input  wire logic       i_fast_osc_enable,
	// CPU events
	input  wire logic       i_sleep_instruction,
	input  wire logic       i_halt_instruction,
	input  wire logic       i_input_interrupt,
	input  wire logic       i_any_interrupt,
	input  wire logic       i_supply_voltage_detector_busy,
	// Status and oscillator controls
	output logic [1:0]      o_mode,
	output logic            o_cpu_clock_select,
	output logic            o_fast_osc_enable,
	output logic            o_slow_osc_run,
	output logic            o_fast_osc_run,
	output logic            o_cpu_clock_run,
	output logic            o_high_speed,
	output logic            o_low_power,
	output dmcc_pkg::dmcc_state_t o_state,
	// Clocks
	output logic            o_cpu_clock,
	output logic            o_timer_clock
);
	import dmcc_pkg::*;

	// ****************************************
	// Control registers
	// ****************************************
	logic [1:0]  mode;
	logic        clk_sel;
	logic        fast_en;
	dmcc_state_t state;
	dmcc_state_t next_state;
	logic        next_low_power;
	logic        next_fast_en;
	logic        running;
	logic        slow_on;
	logic        fast_on;
	logic        cpu_on;
	logic        mux_clk;
	logic        mux_on_fast;
	logic        on_fast_s1;
	logic        on_fast_s2;
	logic        timer_g1;
	logic        timer_g2;

	// Low power mode forces the fast oscillator off whatever software wrote.
	assign next_low_power = (i_mode_select_hi == 1'b0) && (i_mode_select_lo == 1'b1);
	assign next_fast_en   = i_fast_osc_enable & ~next_low_power;
	assign running        = (state == DMCC_RUN);

	always_ff @(posedge i_clock)
	begin
		if (i_rst)
		begin
			mode    <= MODE_RESET;
			clk_sel <= CLK_SELECT_RESET;
			fast_en <= FAST_EN_RESET;
		end
		else if (i_enable && i_ctrl_write && running)
		begin
			mode    <= {i_mode_select_hi, i_mode_select_lo};
			clk_sel <= i_cpu_clock_select & next_fast_en;
			fast_en <= next_fast_en;
		end
	end

	// ****************************************
	// Standby sequencing
	// ****************************************
	always_comb
	begin
		next_state = state;
		case (state)
			DMCC_RUN:
			begin
				if (i_sleep_instruction)
					next_state = DMCC_SLEEP_REQ;
				else if (i_halt_instruction)
					next_state = DMCC_HALT;
			end
			DMCC_HALT:
			begin
				if (i_any_interrupt)
					next_state = DMCC_RUN;
			end
			DMCC_SLEEP_REQ:
			begin
				if (!i_supply_voltage_detector_busy)
					next_state = DMCC_SLEEP;
			end
			DMCC_SLEEP:
			begin
				if (i_input_interrupt)
					next_state = DMCC_RUN;
			end
			default:
				next_state = DMCC_RUN;
		endcase
	end

	always_ff @(posedge i_clock)
	begin
		if (i_rst)
			state <= DMCC_RUN;
		else if (i_enable)
			state <= next_state;
	end

	// ****************************************
	// Oscillator and clock gating
	// ****************************************
	assign slow_on = (state != DMCC_SLEEP);
	assign fast_on = fast_en && (state == DMCC_RUN || state == DMCC_HALT);
	assign cpu_on  = running;

	dmcc_clk_switch u_switch
	(
		.i_slow_clk    (i_slow_osc),
		.i_fast_clk    (i_fast_osc),
		.i_rst         (i_rst),
		.i_select_fast (clk_sel),
		.i_gate        (o_cpu_clock_run),
		.o_clk         (mux_clk),
		.o_on_fast     (mux_on_fast)
	);

	// The CPU clock is gated inside the switch; the timer clock is the slow source behind its own gate.
	assign o_cpu_clock   = mux_clk;
	assign o_timer_clock = i_slow_osc & timer_g2;

	// ****************************************
	// Return of the switch status
	// ****************************************
	always_ff @(posedge i_clock)
	begin
		if (i_rst)
		begin
			on_fast_s1 <= 1'b0;
			on_fast_s2 <= 1'b0;
		end
		else if (i_enable)
		begin
			on_fast_s1 <= mux_on_fast;
			on_fast_s2 <= on_fast_s1;
		end
	end

	// ****************************************
	// Timer clock gate
	// ****************************************
	// The gate moves only while the slow source is low, so no timer pulse is cut.
	always_ff @(negedge i_slow_osc)
	begin
		if (i_rst)
		begin
			timer_g1 <= 1'b1;
			timer_g2 <= 1'b1;
		end
		else
		begin
			timer_g1 <= o_slow_osc_run;
			timer_g2 <= timer_g1;
		end
	end

	always_ff @(posedge i_clock)
	begin
		if (i_rst)
		begin
			o_mode             <= MODE_RESET;
			o_cpu_clock_select <= CLK_SELECT_RESET;
			o_fast_osc_enable  <= FAST_EN_RESET;
			o_slow_osc_run     <= 1'b1;
			o_fast_osc_run     <= 1'b0;
			o_cpu_clock_run    <= 1'b1;
			o_high_speed       <= 1'b0;
			o_low_power        <= 1'b0;
			o_state            <= DMCC_RUN;
		end
		else if (i_enable)
		begin
			o_mode             <= mode;
			o_cpu_clock_select <= on_fast_s2;
			o_fast_osc_enable  <= fast_en;
			o_slow_osc_run     <= slow_on;
			o_fast_osc_run     <= fast_on;
			o_cpu_clock_run    <= cpu_on;
			o_high_speed       <= mode[MODE_HI_BIT];
			o_low_power        <= (mode == MODE_LOW_POWER);
			o_state            <= state;
		end
	end

endmodule // dmcc_clock_control

// file: verilog/dmcc_pkg.sv
// Package of constants and types for the dual oscillator clock control block.
package dmcc_pkg;

	// ****************************************
	// Operating modes
	// ****************************************
	localparam logic [1:0] MODE_NORMAL    = 2'h0;
	localparam logic [1:0] MODE_LOW_POWER = 2'h1;
	localparam int         MODE_HI_BIT    = 1;

	// ****************************************
	// Reset values
	// ****************************************
	localparam logic [1:0] MODE_RESET       = 2'h0;
	localparam logic       CLK_SELECT_RESET = 1'b0;
	localparam logic       FAST_EN_RESET    = 1'b0;

	// ****************************************
	// Nominal figures
	// ****************************************
	localparam int SLOW_OSC_HZ        = 32768;
	localparam int FAST_MAX_NORMAL_HZ = 4200000;
	localparam int FAST_MAX_HIGH_HZ   = 8200000;

	// ****************************************
	// Clock switch handshake
	// ****************************************
	localparam logic [1:0] SYNC_STAGES = 2'h2;

	// ****************************************
	// Standby states
	// ****************************************
	typedef enum logic [1:0]
	{
		DMCC_RUN       = 2'b00,
		DMCC_HALT      = 2'b01,
		DMCC_SLEEP_REQ = 2'b11,
		DMCC_SLEEP     = 2'b10
	} dmcc_state_t;

endpackage // dmcc_pkg
